// ### src/ymdc_transfer_engine.v
// Notes on behaviour
// R1 - Moves 24-bit Y words via 48-bit buffer
// R2 - Two 4K Y blocks; engine has top priority
// R3 - Core access to active block is stalled
// R4 - Status bit 6 shows active block
// R5 - Command bits 5:4: stop, start, continue
// R6 - Status bit 0 reads busy
// R7 - Status bit 1 reads incomplete
// R8 - Sequencer idle/busy driven by three commands
// R9 - Start reloads counter, addresses; continue keeps
// R10 - Config bit 1 selects transfer direction
// R11 - Config bit 0 enables stop interrupt
// R12 - Internal word address, high then low byte
// R13 - External word address, three bytes, reserved
// R14 - Software programs count, at most 4K; code accepts up to 1FFEh
// R15 - Start loads counter from desired number
// R16 - Counter drops once per Y word
// R17 - Count bit 0 fixed at zero
// R18 - Zero count ends transfer, optional interrupt
// R19 - Stop finishes unit, keeps resume state
// R20 - Two Y words pack into three externals
//
// Our own choice: the address-and-strobe port.
`include "ymdc_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module ymdc_transfer_engine (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // Register port
    input  wire [23:0] reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output wire [7:0]  reg_rdata_out,
    // Y-memory side
    output wire [12:0] ymem_addr_out,
    output wire [23:0] ymem_wdata_out,
    output wire        ymem_wr_out,
    output wire        ymem_rd_out,
    input  wire [23:0] ymem_rdata_in,
    output wire [1:0]  ymem_block_busy_out,
    // Memory interface unit side
    output wire        ext_req_out,
    output wire        ext_write_out,
    output wire [23:0] ext_addr_out,
    output wire [15:0] ext_wdata_out,
    input  wire        ext_grant_in,
    input  wire        ext_ready_in,
    input  wire [15:0] ext_rdata_in,
    // Events
    output wire        stop_irq_out
);

    // ============================================================
    // Sequencer states, one-hot; all but idle count as busy
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_NEXT = 5'h02;
    localparam [4:0] S_YRD  = 5'h04;
    localparam [4:0] S_EXT  = 5'h08;
    localparam [4:0] S_YWR  = 5'h10;

    // ============================================================
    // Buffer slicing helpers
    // Word 0 of each side sits at the top of the buffer
    function [15:0] ext_word;
        input [47:0] buf_v;
        input [1:0]  idx;
        begin
            case (idx)
                2'h0:    ext_word = buf_v[47:32];
                2'h1:    ext_word = buf_v[31:16];
                default: ext_word = buf_v[15:0];
            endcase
        end
    endfunction

    function [23:0] y_word;
        input [47:0] buf_v;
        input [1:0]  idx;
        begin
            if (idx == 2'h0) begin
                y_word = buf_v[47:24];
            end else begin
                y_word = buf_v[23:0];
            end
        end
    endfunction

    // ============================================================
    // Software-visible registers
    reg [1:0]  cmd_q;
    reg [1:0]  cfg_q;
    reg [12:0] iadr_q;
    reg [23:0] eadr_q;
    reg [12:0] num_q;

    // Engine state
    reg [4:0]  state_q;
    reg [1:0]  ph_q;
    reg [1:0]  rcv_q;
    reg [47:0] buf_q;
    reg [12:0] igen_q;
    reg [23:0] egen_q;
    reg [12:0] cnt_q;
    reg        incomplete_q;
    reg        stop_pend_q;
    reg        ren_d1_q;

    // Output flops
    reg [7:0]  rdata_q;
    reg [12:0] ymem_addr_q;
    reg [23:0] ymem_wdata_q;
    reg        ymem_we_q;
    reg        ymem_re_q;
    reg [1:0]  blk_busy_q;
    reg        ext_req_q;
    reg        ext_wr_q;
    reg [23:0] ext_addr_q;
    reg [15:0] ext_wdata_q;
    reg        stop_irq_q;

    // ============================================================
    // Command decode
    wire       cmd_wr   = reg_wr_in && (reg_addr_in == `YMDC_OFF_CMD);
    wire [1:0] cmd_val  = reg_wdata_in[`YMDC_CMD_MSB:`YMDC_CMD_LSB];
    wire       start_wr = cmd_wr && (cmd_val == `YMDC_CMD_START); // [R5]
    wire       cont_wr  = cmd_wr && (cmd_val == `YMDC_CMD_CONT);  // [R5]
    wire       stop_wr  = cmd_wr && (cmd_val == `YMDC_CMD_STOP);  // [R5]
    wire       busy     = (state_q != S_IDLE);                    // [R8]
    // Same-cycle stop still counts, so it is never lost
    wire       stop_now = stop_pend_q | stop_wr;
    wire       dir_out  = cfg_q[`YMDC_CFG_DIR_BIT];               // [R10]

    // ============================================================
    // Register writes; config may change any time, takes effect
    // at the next unit boundary
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            cmd_q  <= `YMDC_CMD_RST;
            cfg_q  <= `YMDC_CFG_RST;
            iadr_q <= 13'h0;
            eadr_q <= 24'h0;
            num_q  <= `YMDC_NUM_RST;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `YMDC_OFF_CMD:    cmd_q <= cmd_val;
                `YMDC_OFF_CFG:    cfg_q <= reg_wdata_in[1:0];
                `YMDC_OFF_IADR_H: iadr_q[12:8] <= reg_wdata_in[4:0]; // [R12]
                `YMDC_OFF_IADR_L: iadr_q[7:0]  <= reg_wdata_in;      // [R12]
                `YMDC_OFF_EADR_H: eadr_q[23:16] <= reg_wdata_in;     // [R13]
                `YMDC_OFF_EADR_M: eadr_q[15:8]  <= reg_wdata_in;     // [R13]
                `YMDC_OFF_EADR_L: eadr_q[7:0]   <= reg_wdata_in;     // [R13]
                // Top three bits dropped, bit 0 forced even
                `YMDC_OFF_NUM_H:  num_q[12:8] <= reg_wdata_in[4:0];  // [R14]
                `YMDC_OFF_NUM_L:  num_q[7:0] <= {reg_wdata_in[7:1], 1'b0}; // [R17]
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Read mux; unmapped and reserved bytes read zero
    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        case (reg_addr_in)
            `YMDC_OFF_CMD: begin
                rd_d[`YMDC_BLOCK_BIT]      = igen_q[12];   // [R4]
                rd_d[`YMDC_CMD_MSB:`YMDC_CMD_LSB] = cmd_q;
                rd_d[`YMDC_INCOMPLETE_BIT] = incomplete_q; // [R7]
                rd_d[`YMDC_BUSY_BIT]       = busy;         // [R6]
            end
            `YMDC_OFF_CFG:    rd_d = {6'h00, cfg_q};
            `YMDC_OFF_IADR_H: rd_d = {3'h0, iadr_q[12:8]};
            `YMDC_OFF_IADR_L: rd_d = iadr_q[7:0];
            `YMDC_OFF_EADR_H: rd_d = eadr_q[23:16];
            `YMDC_OFF_EADR_M: rd_d = eadr_q[15:8];
            `YMDC_OFF_EADR_L: rd_d = eadr_q[7:0];
            `YMDC_OFF_NUM_H:  rd_d = {3'h0, num_q[12:8]};
            `YMDC_OFF_NUM_L:  rd_d = num_q[7:0];
            `YMDC_OFF_CNT_H:  rd_d = {3'h0, cnt_q[12:8]};
            // Mid-unit odd value is hidden, bit 0 always reads 0
            `YMDC_OFF_CNT_L:  rd_d = {cnt_q[7:1], 1'b0};   // [R17]
            default:          rd_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd_in ? rd_d : 8'h00;
        end
    end

    // ============================================================
    // Block stall flags for core and coprocessor arbitration
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            blk_busy_q <= 2'h0;
        end else if (busy) begin
            blk_busy_q <= igen_q[12] ? 2'h2 : 2'h1; // [R2] [R3]
        end else begin
            blk_busy_q <= 2'h0;
        end
    end

    // ============================================================
    // Sequencer; a unit is two Y words and three external words,
    // never split, so a stop can only land between units
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q      <= S_IDLE;
            ph_q         <= 2'h0;
            rcv_q        <= 2'h0;
            buf_q        <= 48'h0;
            igen_q       <= 13'h0;
            egen_q       <= 24'h0;
            cnt_q        <= `YMDC_CNT_RST;
            incomplete_q <= 1'b0;
            stop_pend_q  <= 1'b0;
            ren_d1_q     <= 1'b0;
            ymem_addr_q  <= 13'h0;
            ymem_wdata_q <= 24'h0;
            ymem_we_q    <= 1'b0;
            ymem_re_q    <= 1'b0;
            ext_req_q    <= 1'b0;
            ext_wr_q     <= 1'b0;
            ext_addr_q   <= 24'h0;
            ext_wdata_q  <= 16'h0;
            stop_irq_q   <= 1'b0;
        end else begin
            ymem_we_q  <= 1'b0;
            ymem_re_q  <= 1'b0;
            stop_irq_q <= 1'b0;
            ren_d1_q   <= ymem_re_q;
            if (busy && stop_wr) begin
                stop_pend_q <= 1'b1; // [R19]
            end
            case (state_q)
                S_IDLE: begin
                    if (start_wr) begin
                        igen_q       <= iadr_q;              // [R9]
                        egen_q       <= eadr_q;              // [R9]
                        cnt_q        <= num_q;               // [R15]
                        incomplete_q <= (num_q != 13'h0000);
                        state_q      <= S_NEXT;
                    end else if (cont_wr && (cnt_q != 13'h0000)) begin
                        state_q <= S_NEXT;                   // [R9]
                    end
                end
                // Unit boundary: finish, park, or launch a unit
                S_NEXT: begin
                    stop_pend_q <= 1'b0;
                    ph_q        <= 2'h0;
                    rcv_q       <= 2'h0;
                    if (cnt_q == 13'h0000) begin
                        state_q      <= S_IDLE;                 // [R18]
                        incomplete_q <= 1'b0;                   // [R18]
                        stop_irq_q   <= cfg_q[`YMDC_CFG_IRQ_BIT]; // [R11]
                    end else if (stop_now) begin
                        state_q <= S_IDLE;                      // [R19]
                    end else if (dir_out) begin
                        state_q <= S_YRD;                       // [R10]
                    end else begin
                        state_q    <= S_EXT;                    // [R10]
                        ext_req_q  <= 1'b1;
                        ext_wr_q   <= 1'b0;
                        ext_addr_q <= egen_q;
                    end
                end
                // Two Y reads, data back one cycle after each
                S_YRD: begin
                    if (ph_q != 2'h2) begin
                        ymem_re_q   <= 1'b1;
                        ymem_addr_q <= igen_q;
                        igen_q      <= igen_q + 13'h0001;
                        ph_q        <= ph_q + 2'h1;
                    end
                    if (ren_d1_q) begin
                        cnt_q <= cnt_q - 13'h0001;              // [R16]
                        rcv_q <= rcv_q + 2'h1;
                        if (rcv_q == 2'h0) begin
                            buf_q[47:24] <= ymem_rdata_in;      // [R1]
                        end else begin
                            buf_q[23:0] <= ymem_rdata_in;       // [R1]
                            state_q     <= S_EXT;
                            ph_q        <= 2'h0;
                            ext_req_q   <= 1'b1;
                            ext_wr_q    <= 1'b1;
                            ext_addr_q  <= egen_q;
                            ext_wdata_q <= ext_word(buf_q, 2'h0); // [R20]
                        end
                    end
                end
                // Three external words, one address step each
                S_EXT: begin
                    if (ext_req_q && ext_grant_in) begin
                        egen_q      <= egen_q + 24'h1;          // [R20]
                        ext_addr_q  <= egen_q + 24'h1;
                        ext_wdata_q <= ext_word(buf_q, ph_q + 2'h1);
                        ph_q        <= ph_q + 2'h1;
                        if (ph_q == 2'h2) begin
                            ext_req_q <= 1'b0;
                            if (ext_wr_q) begin
                                state_q <= S_NEXT;
                            end
                        end
                    end
                    if (!ext_wr_q && ext_ready_in) begin
                        rcv_q <= rcv_q + 2'h1;
                        case (rcv_q)
                            2'h0:    buf_q[47:32] <= ext_rdata_in; // [R20]
                            2'h1:    buf_q[31:16] <= ext_rdata_in;
                            default: buf_q[15:0]  <= ext_rdata_in;
                        endcase
                        if (rcv_q == 2'h2) begin
                            state_q <= S_YWR;
                            ph_q    <= 2'h0;
                        end
                    end
                end
                // Two Y writes unpacked from the buffer
                S_YWR: begin
                    ymem_we_q    <= 1'b1;
                    ymem_addr_q  <= igen_q;
                    ymem_wdata_q <= y_word(buf_q, ph_q);        // [R1]
                    igen_q       <= igen_q + 13'h0001;
                    cnt_q        <= cnt_q - 13'h0001;           // [R16]
                    ph_q         <= ph_q + 2'h1;
                    if (ph_q == 2'h1) begin
                        state_q <= S_NEXT;
                    end
                end
                default: begin
                    state_q   <= S_IDLE;
                    ext_req_q <= 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // Outputs, each straight from a flop
    assign reg_rdata_out       = rdata_q;
    assign ymem_addr_out       = ymem_addr_q;
    assign ymem_wdata_out      = ymem_wdata_q;
    assign ymem_wr_out         = ymem_we_q;
    assign ymem_rd_out         = ymem_re_q;
    assign ymem_block_busy_out = blk_busy_q;
    assign ext_req_out         = ext_req_q;
    assign ext_write_out       = ext_wr_q;
    assign ext_addr_out        = ext_addr_q;
    assign ext_wdata_out       = ext_wdata_q;
    assign stop_irq_out        = stop_irq_q;

endmodule

`default_nettype wire

// ### src/ymdc_regs.vh
`ifndef YMDC_REGS_VH
`define YMDC_REGS_VH

// ============================================================
// Register byte addresses
`define YMDC_ADDR_W         24
`define YMDC_OFF_CMD        24'h3F0130
`define YMDC_OFF_CFG        24'h3F0131
`define YMDC_OFF_IADR_H     24'h3F0132
`define YMDC_OFF_IADR_L     24'h3F0133
`define YMDC_OFF_EADR_RSV   24'h3F0134
`define YMDC_OFF_EADR_H     24'h3F0135
`define YMDC_OFF_EADR_M     24'h3F0136
`define YMDC_OFF_EADR_L     24'h3F0137
`define YMDC_OFF_NUM_H      24'h3F0138
`define YMDC_OFF_NUM_L      24'h3F0139
`define YMDC_OFF_CNT_H      24'h3F013A
`define YMDC_OFF_CNT_L      24'h3F013B
`define YMDC_OFF_RSV_LO     24'h3F014C
`define YMDC_OFF_RSV_HI     24'h3F014F

// ============================================================
// Command and status field positions
`define YMDC_BUSY_BIT       0
`define YMDC_INCOMPLETE_BIT 1
`define YMDC_CMD_LSB        4
`define YMDC_CMD_MSB        5
`define YMDC_BLOCK_BIT      6

// Commands
`define YMDC_CMD_STOP       2'h0
`define YMDC_CMD_START      2'h1
`define YMDC_CMD_CONT       2'h2

// Configuration field positions
`define YMDC_CFG_IRQ_BIT    0
`define YMDC_CFG_DIR_BIT    1

// ============================================================
// Widths and reset values
`define YMDC_YADDR_W        13
`define YMDC_CNT_W          13
`define YMDC_CMD_RST        2'h0
`define YMDC_CFG_RST        2'h0
`define YMDC_NUM_RST        13'h0000
`define YMDC_CNT_RST        13'h0000

`endif

// ### verification/ymdc_engine_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "ymdc_regs.vh"
// ==========
// Port checks of the transfer engine
module ymdc_engine_checker (
    // Clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    // Register port
    input wire logic [23:0] reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    // Y-memory side
    input wire logic [12:0] ymem_addr_out,
    input wire logic [23:0] ymem_wdata_out,
    input wire logic        ymem_wr_out,
    input wire logic        ymem_rd_out,
    input wire logic [23:0] ymem_rdata_in,
    input wire logic [1:0]  ymem_block_busy_out,
    // Memory interface unit side
    input wire logic        ext_req_out,
    input wire logic        ext_write_out,
    input wire logic [23:0] ext_addr_out,
    input wire logic [15:0] ext_wdata_out,
    input wire logic        ext_grant_in,
    input wire logic        ext_ready_in,
    input wire logic [15:0] ext_rdata_in,
    // Events
    input wire logic        stop_irq_out
);
    logic irq_en_q, dir_q;

    // Config shadow, valid while config written in idle
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_en_q <= 1'b0;
            dir_q    <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == `YMDC_OFF_CFG) begin
            irq_en_q <= reg_wdata_in[0];
            dir_q    <= reg_wdata_in[1];
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_rd_stands;
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
    endproperty
    a_rd_stands: assert property (p_rd_stands)
        else $error("read data outside its cycle");
    property p_status_rsvd;
        reg_rd_in && reg_addr_in == `YMDC_OFF_CMD
            |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[3:2] == 2'h0;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd)
        else $error("status reserved bits set");
    property p_cnt_even;
        reg_rd_in && reg_addr_in == `YMDC_OFF_CNT_L |=> !reg_rdata_out[0];
    endproperty
    a_cnt_even: assert property (p_cnt_even)
        else $error("odd counter");
    property p_eadr_rsvd;
        reg_rd_in && reg_addr_in == `YMDC_OFF_EADR_RSV
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_eadr_rsvd: assert property (p_eadr_rsvd)
        else $error("reserved byte not zero");
    property p_ymem_excl;
        !(ymem_rd_out && ymem_wr_out);
    endproperty
    a_ymem_excl: assert property (p_ymem_excl)
        else $error("Y read and write together");
    property p_block_busy;
        ymem_rd_out || ymem_wr_out
            |=> ymem_block_busy_out[$past(ymem_addr_out[12])];
    endproperty
    a_block_busy: assert property (p_block_busy)
        else $error("active block not flagged");
    property p_req_hold;
        ext_req_out && !ext_grant_in
            |=> ext_req_out && $stable(ext_addr_out) && $stable(ext_write_out);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before grant");
    property p_grant_adv;
        ext_req_out && ext_grant_in ##1 ext_req_out
            |-> ext_addr_out == $past(ext_addr_out) + 24'h1;
    endproperty
    a_grant_adv: assert property (p_grant_adv)
        else $error("external address not advanced");
    property p_dir_match;
        ext_req_out |-> ext_write_out == dir_q;
    endproperty
    a_dir_match: assert property (p_dir_match)
        else $error("wrong direction");
    property p_irq_gate;
        stop_irq_out |-> irq_en_q ##1 !stop_irq_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("bad stop interrupt");
endmodule

bind ymdc_transfer_engine ymdc_engine_checker i_chk (.*);
`default_nettype wire

// ### verification/ymdc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Y-memory and memory interface unit
module ymdc_far_model (
    // Clock, reset, pacing
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        slow_in,
    // Y-memory side
    input  wire logic [12:0] ymem_addr_in,
    input  wire logic [23:0] ymem_wdata_in,
    input  wire logic        ymem_wr_in,
    input  wire logic        ymem_rd_in,
    output logic      [23:0] ymem_rdata_out,
    // Memory interface unit side
    input  wire logic        ext_req_in,
    input  wire logic        ext_write_in,
    input  wire logic [23:0] ext_addr_in,
    input  wire logic [15:0] ext_wdata_in,
    output logic             ext_grant_out,
    output logic             ext_ready_out,
    output logic      [15:0] ext_rdata_out
);
    logic [23:0] ymem_q [0:8191];
    logic [23:0] ext_q [0:255];
    logic [23:0] pend_q [$];
    logic [23:0] pa;
    logic        tick_q;

    // Known Y contents; external reads give 3000h ^ address
    initial begin
        for (int i = 0; i < 8192; i++)
            ymem_q[i] = 24'hC00000 ^ 24'(i);
        tick_q         = 1'b0;
        ymem_rdata_out = 24'h0;
        ext_grant_out  = 1'b0;
        ext_ready_out  = 1'b0;
        ext_rdata_out  = 16'h0;
    end

    // Slow mode answers every other cycle; stale data is inverted
    always @(posedge ref_clk_in) begin
        tick_q         <= ~tick_q;
        ymem_rdata_out <= ~ymem_rdata_out;
        ext_ready_out  <= 1'b0;
        ext_rdata_out  <= ~ext_rdata_out;
        ext_grant_out  <= ext_req_in && !rst_in && (!slow_in || tick_q);
        if (ymem_rd_in)
            ymem_rdata_out <= ymem_q[ymem_addr_in];
        if (ymem_wr_in)
            ymem_q[ymem_addr_in] <= ymem_wdata_in;
        if (rst_in) begin
            pend_q.delete();
        end else if (ext_req_in && ext_grant_out) begin
            if (ext_write_in)
                ext_q[ext_addr_in[7:0]] <= {8'h00, ext_wdata_in};
            else
                pend_q.push_back(ext_addr_in);
        end
        // Read answers come back in request order
        if (pend_q.size() > 0 && (!slow_in || tick_q)) begin
            pa = pend_q.pop_front();
            ext_ready_out <= 1'b1;
            ext_rdata_out <= 16'h3000 ^ pa[15:0];
        end
    end
endmodule
`default_nettype wire

// ### verification/test_ymem_dma_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "ymdc_regs.vh"
// ==========
// Bench for the Y-memory transfer engine
module test_ymem_dma_controller;
    logic        ref_clk_in   = 1'b0;
    logic        rst_in       = 1'b1;
    logic [23:0] reg_addr_in  = 24'h0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic        slow         = 1'b0;
    logic [23:0] irq_cnt      = 24'h0;
    logic [7:0]  d;
    logic [23:0] w0, w1;
    wire  [7:0]  reg_rdata_out;
    wire  [12:0] ymem_addr_out;
    wire  [23:0] ymem_wdata_out, ymem_rdata_in, ext_addr_out;
    wire  [15:0] ext_wdata_out, ext_rdata_in;
    wire  [1:0]  ymem_block_busy_out;
    wire         ymem_wr_out, ymem_rd_out, ext_req_out, ext_write_out;
    wire         ext_grant_in, ext_ready_in, stop_irq_out;
    int          error_cnt = 0;
    int          samples_checked = 0;
    logic [23:0] rst_tab [9] = '{`YMDC_OFF_CMD, `YMDC_OFF_CFG,
        `YMDC_OFF_NUM_H, `YMDC_OFF_NUM_L, `YMDC_OFF_CNT_H, `YMDC_OFF_CNT_L,
        `YMDC_OFF_EADR_RSV, `YMDC_OFF_RSV_LO, `YMDC_OFF_RSV_HI};

    always #50 ref_clk_in = ~ref_clk_in;

    ymdc_transfer_engine i_dut (
        .ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .ymem_addr_out, .ymem_wdata_out,
        .ymem_wr_out, .ymem_rd_out, .ymem_rdata_in, .ymem_block_busy_out,
        .ext_req_out, .ext_write_out, .ext_addr_out, .ext_wdata_out,
        .ext_grant_in, .ext_ready_in, .ext_rdata_in, .stop_irq_out
    );

    ymdc_far_model i_far (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .slow_in(slow),
        .ymem_addr_in(ymem_addr_out), .ymem_wdata_in(ymem_wdata_out),
        .ymem_wr_in(ymem_wr_out), .ymem_rd_in(ymem_rd_out),
        .ymem_rdata_out(ymem_rdata_in), .ext_req_in(ext_req_out),
        .ext_write_in(ext_write_out), .ext_addr_in(ext_addr_out),
        .ext_wdata_in(ext_wdata_out), .ext_grant_out(ext_grant_in),
        .ext_ready_out(ext_ready_in), .ext_rdata_out(ext_rdata_in)
    );

    // Count stop interrupt pulses
    always @(posedge ref_clk_in) begin
        if (stop_irq_out === 1'b1)
            irq_cnt <= irq_cnt + 24'h1;
    end

    task chk(input string nm, input logic [23:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [23:0] a, input logic [7:0] v);
        @(posedge ref_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in    <= 1'b0;
    endtask

    task rchk(input string nm, input logic [23:0] a, e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in   <= 1'b0;
        #1 d = reg_rdata_out;
        if (nm != "")
            chk(nm, {16'h0, d}, e);
    endtask

    task setup(input logic [12:0] ia, n, input logic [23:0] ea,
               input logic [7:0] c);
        wr(`YMDC_OFF_IADR_H, {3'h0, ia[12:8]});
        wr(`YMDC_OFF_IADR_L, ia[7:0]);
        wr(`YMDC_OFF_EADR_H, ea[23:16]);
        wr(`YMDC_OFF_EADR_M, ea[15:8]);
        wr(`YMDC_OFF_EADR_L, ea[7:0]);
        wr(`YMDC_OFF_NUM_H, {3'h0, n[12:8]});
        wr(`YMDC_OFF_NUM_L, n[7:0]);
        wr(`YMDC_OFF_CFG, c);
    endtask

    task wait_idle;
        d = 8'hFF;
        for (int i = 0; i < 300 && d[0] !== 1'b0; i++)
            rchk("", `YMDC_OFF_CMD, 24'h0);
        chk("idle", {23'h0, d[0]}, 24'h0);
    endtask

    // Two Y words land as three external words, big end first
    task ext_unit(input logic [7:0] e, input logic [12:0] ya);
        w0 = 24'hC00000 ^ {11'h0, ya};
        w1 = 24'hC00000 ^ {11'h0, ya + 13'h1};
        chk("ext0", i_far.ext_q[e], {8'h00, w0[23:8]});
        chk("ext1", i_far.ext_q[e + 8'h01], {8'h00, w0[7:0], w1[23:16]});
        chk("ext2", i_far.ext_q[e + 8'h02], {8'h00, w1[15:0]});
    endtask

    task end_of_test;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Run needs under 300 cycles
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        error_cnt++;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        foreach (rst_tab[i])
            rchk("reset", rst_tab[i], 24'h0);
        wr(`YMDC_OFF_NUM_H, 8'hFF);
        rchk("num_h", `YMDC_OFF_NUM_H, 24'h1F);
        wr(`YMDC_OFF_NUM_L, 8'h07);
        rchk("num_l", `YMDC_OFF_NUM_L, 24'h06);
        wr(`YMDC_OFF_CFG, 8'hFF);
        rchk("cfg", `YMDC_OFF_CFG, 24'h03);
        wr(`YMDC_OFF_RSV_LO, 8'hFF);
        rchk("rsvd", `YMDC_OFF_RSV_LO, 24'h00);
        rchk("cnt", `YMDC_OFF_CNT_L, 24'h00);
        $display("Test registers done");
        // Y-memory to external, block 1, interrupt on
        setup(13'h1000, 13'h0004, 24'h000020, 8'h03);
        wr(`YMDC_OFF_CMD, 8'h10);
        rchk("busy", `YMDC_OFF_CMD, 24'h53);
        wait_idle;
        rchk("done", `YMDC_OFF_CMD, 24'h50);
        rchk("cnt", `YMDC_OFF_CNT_L, 24'h00);
        ext_unit(8'h20, 13'h1000);
        ext_unit(8'h23, 13'h1002);
        chk("irq", irq_cnt, 24'h1);
        $display("Test outbound done");
        // External to Y-memory, interrupt off
        setup(13'h0002, 13'h0002, 24'h000040, 8'h00);
        wr(`YMDC_OFF_CMD, 8'h10);
        wait_idle;
        chk("y0", i_far.ymem_q[2], 24'h304030);
        chk("y1", i_far.ymem_q[3], 24'h413042);
        chk("irq", irq_cnt, 24'h1);
        $display("Test inbound done");
        // Stop mid-transfer against a slow far side, then resume
        slow <= 1'b1;
        setup(13'h0800, 13'h0008, 24'h000080, 8'h02);
        wr(`YMDC_OFF_CMD, 8'h10);
        repeat (2) @(posedge ref_clk_in);
        wr(`YMDC_OFF_CMD, 8'h00);
        wait_idle;
        rchk("held", `YMDC_OFF_CNT_L, 24'h06);
        rchk("stopped", `YMDC_OFF_CMD, 24'h02);
        wr(`YMDC_OFF_CMD, 8'h20);
        wait_idle;
        rchk("resumed", `YMDC_OFF_CMD, 24'h20);
        for (int u = 0; u < 4; u++)
            ext_unit(8'h80 + 8'(u * 3), 13'h0800 + 13'(u * 2));
        $display("Test stop and resume done");
        end_of_test;
    end
endmodule
`default_nettype wire
